// >>> common/pbt_defines.svh
// Offsets, indices, reset values and timing counts of the bus timing block
`ifndef PBT_DEFINES_SVH
`define PBT_DEFINES_SVH

`define PBT_PORT_POINTER     8'h72
`define PBT_PORT_DATA        8'h73
`define PBT_PORT_BUSY_CLEAR  8'hf0
`define PBT_PORT_COP_RESET   8'hf1

`define PBT_IDX_BALE_DELAY   4'h0
`define PBT_IDX_BALE_WIDTH   4'h1
`define PBT_IDX_SLOW_DELAY   4'h3
`define PBT_IDX_EIGHT_WAITS  4'h4
`define PBT_IDX_IO16_WAITS   4'h5
`define PBT_IDX_M16_DELAY    4'h6
`define PBT_IDX_M16_WAITS    4'h7
`define PBT_IDX_M16_ZW_WAITS 4'h8
`define PBT_IDX_LRD_WAITS    4'h9
`define PBT_IDX_LWR_WAITS    4'ha
`define PBT_IDX_LIO_DELAY    4'hc

`define PBT_RST_BALE_DELAY   2'h0
`define PBT_RST_BALE_WIDTH   2'h1
`define PBT_RST_SLOW_DELAY   4'h1
`define PBT_RST_EIGHT_WAITS  4'h4
`define PBT_RST_IO16_WAITS   4'h1
`define PBT_RST_M16_DELAY    4'h0
`define PBT_RST_M16_WAITS    4'h1
`define PBT_RST_M16_ZW_WAITS 4'h0
`define PBT_RST_LRD_WAITS    4'h1
`define PBT_RST_LWR_WAITS    4'h1
`define PBT_RST_LIO_DELAY    4'h1

`define PBT_CLK_MHZ          20
`define PBT_COP_RESET_NS     500
`define PBT_COP_RESET_CYCLES ((`PBT_COP_RESET_NS * `PBT_CLK_MHZ + 999) / 1000)
`define PBT_CLKS_PER_WAIT    6'h02
`define PBT_BASE_CMD_CLKS    6'h02
`define PBT_READY_LEAD       6'h02

`endif

// >>> common/pbt_pkg.sv
// Types shared by the bus timing block
package pbt_pkg;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] data;
    } pbt_io_req_s;

    typedef struct packed {
        logic is_mem;
        logic is_write;
        logic mem_wide_select_n;
        logic io_wide_select_n;
        logic local_cycle_n;
    } pbt_cycle_s;

    typedef enum logic [2:0] {
        PBT_CLS_MEM8, PBT_CLS_IO8, PBT_CLS_IO16, PBT_CLS_MEM16, PBT_CLS_LOCAL_MEM,
        PBT_CLS_LOCAL_IO
    } pbt_class_e;

    typedef struct packed {
        logic [3:0] cmd_delay;
        logic [3:0] waits;
        logic       zero_wait_ok;
        pbt_class_e cls;
    } pbt_timing_s;

endpackage

// >>> rtl/pbt_bus_timing.sv
// Programmable bus cycle timing, indexed timing registers and coprocessor ports
`timescale 1ns/10ps
`include "pbt_defines.svh"
`default_nettype none

module pbt_bus_timing
    import pbt_pkg::*;
#(
    parameter int COP_RESET_CYCLES = `PBT_COP_RESET_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire pbt_io_req_s io_req,
    input  wire logic        addr_latch_strobe,
    input  wire pbt_cycle_s  cycle_info,
    input  wire logic        zero_wait_request_n,
    input  wire logic        iochrdy,
    input  wire logic        coproc_busy_in_n,
    input  wire logic        coproc_error_n,
    output var  logic        bale,
    output var  logic        command,
    output var  logic        cycle_done,
    output var  pbt_class_e  cycle_class,
    output var  logic        coproc_hold_n,
    output var  logic        coproc_reset
);

    localparam int RST_CNT_W = $clog2(COP_RESET_CYCLES + 1);

    generate
        if (COP_RESET_CYCLES < 1) begin : g_bad_reset_len
            $error("COP_RESET_CYCLES must be at least one");
        end
    endgenerate

    typedef enum logic [1:0] {
        ST_IDLE, ST_DELAY, ST_CMD
    } pbt_state_e;

    // Register index from pointer bits 7, 6, 3 and 2
    function automatic logic [3:0] pointer_index(input logic [7:0] p);
        return {p[7], p[6], p[3], p[2]};
    endfunction

    // Clocks of command phase for a given wait-state count
    function automatic logic [5:0] phase_clocks(input logic [3:0] w);
        return `PBT_BASE_CMD_CLKS + `PBT_CLKS_PER_WAIT * {2'h0, w};
    endfunction

    // Timing register file
    logic [7:0]  pointer;
    logic [1:0]  bale_delay;
    logic [1:0]  bale_width;
    logic [3:0]  slow_cmd_delay;
    logic [3:0]  eight_bit_waits;
    logic [3:0]  io16_waits;
    logic [3:0]  mem16_cmd_delay;
    logic [3:0]  mem16_waits;
    logic [3:0]  mem16_zero_wait_waits;
    logic [3:0]  local_read_waits;
    logic [3:0]  local_write_waits;
    logic [3:0]  local_io_cmd_delay;

    // Port decode
    wire         wr_pointer = io_req.write && (io_req.addr == `PBT_PORT_POINTER);
    wire         wr_data    = io_req.write && (io_req.addr == `PBT_PORT_DATA);
    wire         wr_busy_clr = io_req.write && (io_req.addr == `PBT_PORT_BUSY_CLEAR);
    wire         wr_cop_rst = io_req.write && (io_req.addr == `PBT_PORT_COP_RESET);
    wire [3:0]   sel_index  = pointer_index(pointer);
    wire [7:0]   wdata      = io_req.data;

    // Unused numbers match no load strobe and are dropped
    wire ld_bale_delay = wr_data && (sel_index == `PBT_IDX_BALE_DELAY);
    wire ld_bale_width = wr_data && (sel_index == `PBT_IDX_BALE_WIDTH);
    wire ld_slow_delay = wr_data && (sel_index == `PBT_IDX_SLOW_DELAY);
    wire ld_eight_wait = wr_data && (sel_index == `PBT_IDX_EIGHT_WAITS);
    wire ld_io16_wait  = wr_data && (sel_index == `PBT_IDX_IO16_WAITS);
    wire ld_m16_delay  = wr_data && (sel_index == `PBT_IDX_M16_DELAY);
    wire ld_m16_wait   = wr_data && (sel_index == `PBT_IDX_M16_WAITS);
    wire ld_m16_zw     = wr_data && (sel_index == `PBT_IDX_M16_ZW_WAITS);
    wire ld_lrd_wait   = wr_data && (sel_index == `PBT_IDX_LRD_WAITS);
    wire ld_lwr_wait   = wr_data && (sel_index == `PBT_IDX_LWR_WAITS);
    wire ld_lio_delay  = wr_data && (sel_index == `PBT_IDX_LIO_DELAY);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pointer <= 8'h00;
        end else if (wr_pointer) begin
            pointer <= wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bale_delay            <= `PBT_RST_BALE_DELAY;
            bale_width            <= `PBT_RST_BALE_WIDTH;
            slow_cmd_delay        <= `PBT_RST_SLOW_DELAY;
            eight_bit_waits       <= `PBT_RST_EIGHT_WAITS;
            io16_waits            <= `PBT_RST_IO16_WAITS;
            mem16_cmd_delay       <= `PBT_RST_M16_DELAY;
            mem16_waits           <= `PBT_RST_M16_WAITS;
            mem16_zero_wait_waits <= `PBT_RST_M16_ZW_WAITS;
            local_read_waits      <= `PBT_RST_LRD_WAITS;
            local_write_waits     <= `PBT_RST_LWR_WAITS;
            local_io_cmd_delay    <= `PBT_RST_LIO_DELAY;
        end else begin
            if (ld_bale_delay) bale_delay <= wdata[1:0];
            if (ld_bale_width) bale_width <= wdata[1:0];
            if (ld_slow_delay) slow_cmd_delay <= wdata[3:0];
            if (ld_eight_wait) eight_bit_waits <= wdata[3:0];
            if (ld_io16_wait) io16_waits <= wdata[3:0];
            if (ld_m16_delay) mem16_cmd_delay <= wdata[3:0];
            if (ld_m16_wait) mem16_waits <= wdata[3:0];
            if (ld_m16_zw) mem16_zero_wait_waits <= wdata[3:0];
            if (ld_lrd_wait) local_read_waits <= wdata[3:0];
            if (ld_lwr_wait) local_write_waits <= wdata[3:0];
            if (ld_lio_delay) local_io_cmd_delay <= wdata[3:0];
        end
    end

    // Cycle classification, taken when the address strobe ends
    pbt_timing_s cls_timing;
    wire         local_waits_sel = cycle_info.is_write;
    wire [3:0]   local_waits = local_waits_sel ? local_write_waits : local_read_waits;

    always_comb begin
        cls_timing = '{cmd_delay: slow_cmd_delay, waits: eight_bit_waits,
                       zero_wait_ok: 1'b0, cls: PBT_CLS_MEM8};
        if (!cycle_info.local_cycle_n) begin
            if (cycle_info.is_mem) begin
                cls_timing.cmd_delay = 4'h0;
                cls_timing.cls       = PBT_CLS_LOCAL_MEM;
            end else begin
                cls_timing.cmd_delay = local_io_cmd_delay;
                cls_timing.cls       = PBT_CLS_LOCAL_IO;
            end
            cls_timing.waits = local_waits;
        end else if (cycle_info.is_mem) begin
            if (!cycle_info.mem_wide_select_n) begin
                cls_timing.cmd_delay    = mem16_cmd_delay;
                cls_timing.waits        = mem16_waits;
                cls_timing.zero_wait_ok = 1'b1;
                cls_timing.cls          = PBT_CLS_MEM16;
            end
        end else if (!cycle_info.io_wide_select_n) begin
            cls_timing.waits = io16_waits;
            cls_timing.cls   = PBT_CLS_IO16;
        end else begin
            cls_timing.cls = PBT_CLS_IO8;
        end
    end

    // Strobe edge detection
    logic strobe_q;
    wire  strobe_rise = addr_latch_strobe && !strobe_q;
    wire  strobe_fall = !addr_latch_strobe && strobe_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= addr_latch_strobe;
        end
    end

    // BALE generator: delay from strobe leading edge, then programmed width
    logic       bale_pending;
    logic [1:0] bale_dly_cnt;
    logic [1:0] bale_wid_cnt;
    wire        bale_fire = (strobe_rise && (bale_delay == 2'h0))
                            || (bale_pending && (bale_dly_cnt == 2'h1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bale_pending <= 1'b0;
            bale_dly_cnt <= 2'h0;
        end else if (strobe_rise && (bale_delay != 2'h0)) begin
            bale_pending <= 1'b1;
            bale_dly_cnt <= bale_delay;
        end else if (bale_pending) begin
            bale_dly_cnt <= bale_dly_cnt - 2'h1;
            bale_pending <= (bale_dly_cnt != 2'h1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bale         <= 1'b0;
            bale_wid_cnt <= 2'h0;
        end else if (bale_fire) begin
            bale         <= (bale_width != 2'h0);
            bale_wid_cnt <= bale_width;
        end else if (bale) begin
            bale         <= (bale_wid_cnt != 2'h1);
            bale_wid_cnt <= bale_wid_cnt - 2'h1;
        end
    end

    // Command sequencer
    pbt_state_e  state;
    pbt_state_e  next_state;
    pbt_timing_s cur;
    logic [3:0]  dly_cnt;
    logic [5:0]  elapsed;
    logic [5:0]  next_elapsed;
    logic        next_done;

    wire [5:0] end_at    = phase_clocks(cur.waits);
    wire [5:0] zw_end    = phase_clocks(mem16_zero_wait_waits);
    wire [5:0] elapsed_1 = elapsed + 6'h01;
    // Ready sample point lies one clock before the normal end
    wire       at_ready_pt = (elapsed + `PBT_READY_LEAD == end_at);
    wire       stretch   = at_ready_pt && !iochrdy;
    // Zero-wait request honoured at or after its shorter end point
    wire       zw_hit    = cur.zero_wait_ok && !zero_wait_request_n
                           && (elapsed_1 >= zw_end);
    wire       normal_end = (elapsed_1 == end_at);

    always_comb begin
        next_state   = state;
        next_elapsed = elapsed;
        next_done    = 1'b0;
        case (state)
            ST_IDLE: begin
                next_elapsed = 6'h00;
                if (strobe_fall) begin
                    next_state = (cls_timing.cmd_delay == 4'h0) ? ST_CMD : ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (dly_cnt == 4'h1) begin
                    next_state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (zw_hit || (normal_end && !stretch)) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                end else if (!stretch) begin
                    next_elapsed = elapsed_1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state   <= ST_IDLE;
            elapsed <= 6'h00;
            command <= 1'b0;
            cycle_done <= 1'b0;
        end else begin
            state   <= next_state;
            elapsed <= next_elapsed;
            command <= (next_state == ST_CMD);
            cycle_done <= next_done;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur         <= '{cmd_delay: 4'h0, waits: 4'h0, zero_wait_ok: 1'b0,
                             cls: PBT_CLS_MEM8};
            dly_cnt     <= 4'h0;
            cycle_class <= PBT_CLS_MEM8;
        end else if ((state == ST_IDLE) && strobe_fall) begin
            cur         <= cls_timing;
            dly_cnt     <= cls_timing.cmd_delay;
            cycle_class <= cls_timing.cls;
        end else if (state == ST_DELAY) begin
            dly_cnt <= dly_cnt - 4'h1;
        end
    end

    // Coprocessor busy latch: an error arriving with the clear keeps it set
    logic busy_latched;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_latched <= 1'b0;
        end else if (!coproc_error_n) begin
            busy_latched <= 1'b1;
        end else if (wr_busy_clr) begin
            busy_latched <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coproc_hold_n <= 1'b1;
        end else begin
            coproc_hold_n <= !(busy_latched || !coproc_busy_in_n || !coproc_error_n);
        end
    end

    // Coprocessor reset pulse; a new write restarts the full length
    logic [RST_CNT_W-1:0] rst_cnt;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_cnt      <= '0;
            coproc_reset <= 1'b0;
        end else if (wr_cop_rst) begin
            rst_cnt      <= RST_CNT_W'(COP_RESET_CYCLES - 1);
            coproc_reset <= 1'b1;
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
        end else begin
            coproc_reset <= 1'b0;
        end
    end

endmodule // pbt_bus_timing

`default_nettype wire

// >>> testbench/pbt_bus_peer.sv
// Expansion board model: ready stretch and zero-wait request
`timescale 1ns/10ps
`default_nettype none

module pbt_bus_peer (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       command,
    input  wire logic [7:0] stall_clks,
    input  wire logic       zw_en,
    output logic            iochrdy,
    output logic            zero_wait_request_n
);
    logic [7:0] cnt;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt <= 8'h00;
        else if (!command) cnt <= 8'h00;
        else if (cnt != 8'hff) cnt <= cnt + 8'h01;
    end

    // Not ready for the first stall_clks clocks of the command; pulled up otherwise
    assign iochrdy = !(command && cnt < stall_clks);
    // Request held for the whole command, so it is set up before the normal end
    assign zero_wait_request_n = !(zw_en && command);
endmodule // pbt_bus_peer

`default_nettype wire

// >>> testbench/pbt_bus_timing_sva.sv
// Port-level checker for the bus timing block
`timescale 1ns/10ps
`include "pbt_defines.svh"
`default_nettype none

module pbt_bus_timing_sva
    import pbt_pkg::*;
#(
    parameter int COP_RESET_CYCLES = 10
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire pbt_io_req_s io_req,
    input wire logic        addr_latch_strobe,
    input wire pbt_cycle_s  cycle_info,
    input wire logic        zero_wait_request_n,
    input wire logic        iochrdy,
    input wire logic        coproc_busy_in_n,
    input wire logic        coproc_error_n,
    input wire logic        bale,
    input wire logic        command,
    input wire logic        cycle_done,
    input wire pbt_class_e  cycle_class,
    input wire logic        coproc_hold_n,
    input wire logic        coproc_reset
);
    logic [7:0] pulse_cnt;
    wire        f0_wr = io_req.write && io_req.addr == `PBT_PORT_BUSY_CLEAR;
    wire        f1_wr = io_req.write && io_req.addr == `PBT_PORT_COP_RESET;

    // Cycles since the last coprocessor reset write, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pulse_cnt <= 8'hff;
        else if (f1_wr) pulse_cnt <= 8'h00;
        else if (pulse_cnt != 8'hff) pulse_cnt <= pulse_cnt + 8'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_cop_pulse; coproc_reset == (pulse_cnt < COP_RESET_CYCLES); endproperty
    a_cop_pulse: assert property (p_cop_pulse) else $error("coproc reset pulse wrong");
    property p_err_latch; !coproc_error_n |=> !coproc_hold_n; endproperty
    a_err_latch: assert property (p_err_latch) else $error("busy not set on error");
    property p_err_hold; (!coproc_error_n ##1 !f0_wr ##1 !f0_wr) |-> !coproc_hold_n; endproperty
    a_err_hold: assert property (p_err_hold) else $error("busy latch lost");
    property p_busy_clear;
        (f0_wr && coproc_error_n && coproc_busy_in_n ##1 coproc_error_n && coproc_busy_in_n)
            |=> coproc_hold_n;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");
    property p_done_after; $fell(command) |-> cycle_done; endproperty
    a_done_after: assert property (p_done_after) else $error("no done after command");
    property p_done_pulse; cycle_done |=> !cycle_done && !command; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
    property p_cmd_after_strobe; $rose(command) |-> !addr_latch_strobe; endproperty
    a_cmd_after_strobe: assert property (p_cmd_after_strobe) else $error("early command");
    property p_bale_cause;
        $rose(bale) |-> $past(addr_latch_strobe) || $past(addr_latch_strobe, 2)
            || $past(addr_latch_strobe, 3) || $past(addr_latch_strobe, 4);
    endproperty
    a_bale_cause: assert property (p_bale_cause) else $error("bale without strobe");
    property p_bale_width; $rose(bale) |-> ##[1:3] !bale; endproperty
    a_bale_width: assert property (p_bale_width) else $error("bale too wide");
    property p_class_stable; command && $past(command) |-> $stable(cycle_class); endproperty
    a_class_stable: assert property (p_class_stable) else $error("class moved");
endmodule // pbt_bus_timing_sva

bind pbt_bus_timing pbt_bus_timing_sva #(.COP_RESET_CYCLES(COP_RESET_CYCLES)) u_sva (.*);

`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the bus timing block
`timescale 1ns/10ps
`include "pbt_defines.svh"
`default_nettype none

module testbench;
    import pbt_pkg::*;
    logic        clk, reset_n, addr_latch_strobe, iochrdy, zero_wait_request_n;
    logic        coproc_busy_in_n, coproc_error_n, bale, command, cycle_done;
    logic        coproc_hold_n, coproc_reset, zw_en;
    logic [7:0]  stall_clks;
    pbt_io_req_s io_req;
    pbt_cycle_s  cycle_info;
    pbt_class_e  cycle_class;
    int          mismatches = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Register numbers with no timing register behind them
    logic [3:0]  unused_idx [5] = '{4'h2, 4'hb, 4'hd, 4'he, 4'hf};

    pbt_bus_timing #(.COP_RESET_CYCLES(2)) pbt_bus_timing_inst (
        .clk(clk), .reset_n(reset_n), .io_req(io_req), .addr_latch_strobe(addr_latch_strobe),
        .cycle_info(cycle_info), .zero_wait_request_n(zero_wait_request_n), .iochrdy(iochrdy),
        .coproc_busy_in_n(coproc_busy_in_n), .coproc_error_n(coproc_error_n), .bale(bale),
        .command(command), .cycle_done(cycle_done), .cycle_class(cycle_class),
        .coproc_hold_n(coproc_hold_n), .coproc_reset(coproc_reset));
    pbt_bus_peer pbt_bus_peer_inst (
        .clk(clk), .reset_n(reset_n), .command(command), .stall_clks(stall_clks),
        .zw_en(zw_en), .iochrdy(iochrdy), .zero_wait_request_n(zero_wait_request_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io_req <= '{1'b1, a, d};
        @(posedge clk);
        io_req.write <= 1'b0;
    endtask

    // Index travels in pointer bits 7,6,3,2
    task automatic setr(input logic [3:0] i, input logic [7:0] v);
        wr(`PBT_PORT_POINTER, {i[3:2], 2'b00, i[1:0], 2'b00});
        wr(`PBT_PORT_DATA, v);
    endtask

    // Strobe high four clocks; delays counted from its rise and its end
    task automatic cyc(input pbt_cycle_s ci, input int bd, bw, d, len, input pbt_class_e cls);
        int first, n, dk;
        logic [7:0] bp, ep;
        first = -1;
        n = 0;
        dk = -1;
        bp = '0;
        for (int i = 0; i < 8; i++) ep[i] = (i >= bd && i < bd + bw);
        @(posedge clk);
        addr_latch_strobe <= 1'b1;
        cycle_info <= ci;
        for (int k = 0; k < 60; k++) begin
            @(posedge clk);
            if (k == 3) addr_latch_strobe <= 1'b0;
            #1;
            if (k < 8) bp[k] = bale;
            if (command === 1'b1) begin
                if (first < 0) first = k - 4;
                n++;
            end
            if (cycle_done === 1'b1 && dk < 0) begin
                dk = k;
                chk("class", cycle_class, cls);
            end
        end
        chk("bale", bp, ep);
        chk("delay", first, d);
        chk("length", n, len);
        chk("done", dk, first + 4 + n);
    endtask

    initial begin
        io_req = '0;
        addr_latch_strobe = 1'b0;
        cycle_info = 5'b10111;
        coproc_busy_in_n = 1'b1;
        coproc_error_n = 1'b1;
        stall_clks = 8'h00;
        zw_en = 1'b0;
        reset_n = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        cyc(5'b10111, 0, 1, 1, 10, PBT_CLS_MEM8);
        cyc(5'b00111, 0, 1, 1, 10, PBT_CLS_IO8);
        cyc(5'b00101, 0, 1, 1, 4, PBT_CLS_IO16);
        cyc(5'b10011, 0, 1, 0, 4, PBT_CLS_MEM16);
        zw_en <= 1'b1;
        cyc(5'b10011, 0, 1, 0, 2, PBT_CLS_MEM16);
        setr(`PBT_IDX_M16_DELAY, 8'h02);
        setr(`PBT_IDX_M16_WAITS, 8'h05);
        setr(`PBT_IDX_M16_ZW_WAITS, 8'h02);
        cyc(5'b10011, 0, 1, 2, 6, PBT_CLS_MEM16);
        zw_en <= 1'b0;
        cyc(5'b10011, 0, 1, 2, 12, PBT_CLS_MEM16);
        cyc(5'b10000, 0, 1, 0, 4, PBT_CLS_LOCAL_MEM);
        setr(`PBT_IDX_LWR_WAITS, 8'h03);
        cyc(5'b11110, 0, 1, 0, 8, PBT_CLS_LOCAL_MEM);
        cyc(5'b10110, 0, 1, 0, 4, PBT_CLS_LOCAL_MEM);
        setr(`PBT_IDX_LIO_DELAY, 8'hf3);
        cyc(5'b01110, 0, 1, 3, 8, PBT_CLS_LOCAL_IO);
        setr(`PBT_IDX_BALE_DELAY, 8'hfe);
        setr(`PBT_IDX_BALE_WIDTH, 8'h03);
        setr(`PBT_IDX_SLOW_DELAY, 8'h02);
        setr(`PBT_IDX_EIGHT_WAITS, 8'h00);
        cyc(5'b10111, 2, 3, 2, 2, PBT_CLS_MEM8);
        for (int j = 0; j < 5; j++) setr(unused_idx[j], 8'hff);
        cyc(5'b10111, 2, 3, 2, 2, PBT_CLS_MEM8);
        setr(`PBT_IDX_EIGHT_WAITS, 8'h04);
        stall_clks <= 8'd12;
        cyc(5'b10111, 2, 3, 2, 14, PBT_CLS_MEM8);
        stall_clks <= 8'd5;
        cyc(5'b10111, 2, 3, 2, 10, PBT_CLS_MEM8);
        stall_clks <= 8'd0;
        // Error and clear in the same cycle: the set must win
        @(posedge clk);
        io_req <= '{1'b1, `PBT_PORT_BUSY_CLEAR, 8'h00};
        coproc_error_n <= 1'b0;
        @(posedge clk);
        io_req.write <= 1'b0;
        coproc_error_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("hold_n", coproc_hold_n, 1'b0);
        wr(`PBT_PORT_BUSY_CLEAR, 8'h5a);
        repeat (2) @(posedge clk);
        #1;
        chk("hold_n", coproc_hold_n, 1'b1);
        wr(`PBT_PORT_COP_RESET, 8'h00);
        #1;
        chk("cop_reset", coproc_reset, 1'b1);
        @(posedge clk);
        #1;
        chk("cop_reset", coproc_reset, 1'b1);
        @(posedge clk);
        #1;
        chk("cop_reset", coproc_reset, 1'b0);
        final_report();
    end
endmodule // testbench

`default_nettype wire
